// *** core/rcgc_consts.svh ***
// Constants for the read channel gain control block
`ifndef RCGC_CONSTS_SVH
`define RCGC_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses on the serial control port
// ----------------------------------------------------------------
`define RCGC_ADDR_SLEEP 4'h8
`define RCGC_ADDR_MODE 4'h9
`define RCGC_ADDR_DGAIN 4'hB
`define RCGC_ADDR_SGAIN 4'hC

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define RCGC_SLEEP_BIT 7
`define RCGC_PGC_BIT 7
`define RCGC_GAIN_MSB 4
`define RCGC_REG_RESET 8'h00
`define RCGC_TEST_BYPASS 3'h5

// ----------------------------------------------------------------
// Bit positions of the one-hot pump code
// ----------------------------------------------------------------
`define RCGC_PUMP_CHG_N_BIT 1
`define RCGC_PUMP_DIS_N_BIT 2
`define RCGC_PUMP_DIS_F_BIT 3
`define RCGC_PUMP_CHG_F_BIT 4

// ----------------------------------------------------------------
// Serial frame layout: 4 address bits then 8 data bits, MSB first
// ----------------------------------------------------------------
`define RCGC_FRAME_BITS 4'hC
`define RCGC_ADDR_HI 11
`define RCGC_ADDR_LO 8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RCGC_CLK_NS 25
`define RCGC_LOW_IMPEDANCE_REQUEST_EXT_NS 200
`define RCGC_LOW_IMPEDANCE_REQUEST_EXT_CYC ((`RCGC_LOW_IMPEDANCE_REQUEST_EXT_NS + `RCGC_CLK_NS - 1) / `RCGC_CLK_NS)

`endif

// *** core/rcgc_low_impedance_request_if.sv ***
// Link between the gain controller and the low impedance extension timer
`timescale 1ns/1ps
`default_nettype none

interface rcgc_low_impedance_request_if;
   logic req;
   logic extend;

   // Controller side
   modport ctrl (output req, input extend);
   // Timer side
   modport timer (input req, output extend);
endinterface

`default_nettype wire

// *** core/rcgc_low_impedance_request_timer.sv ***
// Holds the coupling network in low impedance after request release
`timescale 1ns/1ps
`default_nettype none
`include "rcgc_consts.svh"

module rcgc_low_impedance_request_timer #(
   parameter int EXT_CYC = `RCGC_LOW_IMPEDANCE_REQUEST_EXT_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic nrst_i,
   // Request in, extension out
   rcgc_low_impedance_request_if.timer lz
);

   localparam int CW = $clog2(EXT_CYC + 1);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (EXT_CYC < 1) begin : g_bad_ext
      $error("EXT_CYC must be at least one");
   end

   typedef struct packed {
      logic [CW-1:0] cnt;
   } rcgc_timer_s;

   rcgc_timer_s st_ff;
   rcgc_timer_s nxt_st;

   // Reload while requested, count down after release
   always_comb begin
      nxt_st = st_ff;
      if (lz.req) begin
         nxt_st.cnt = CW'(EXT_CYC); // R10
      end else if (st_ff.cnt != '0) begin
         nxt_st.cnt = st_ff.cnt - CW'(1); // R10
      end
   end

   // State register
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Extension active while count is nonzero
   assign lz.extend = (st_ff.cnt != '0);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   a_ext_after_release: assert property ($fell(lz.req) |-> lz.extend [*8]) // R10
      else $error("Extension shorter than required");

   a_ext_ends_bound: assert property (
      (!lz.req && st_ff.cnt == CW'(1)) |=> !lz.extend) // R10
      else $error("Extension did not end");

   c_ext_full: cover property ($fell(lz.req) ##8 !lz.extend);

endmodule // rcgc_low_impedance_request_timer

`default_nettype wire

// *** core/rcgc_pkg.sv ***
// Types for the read channel gain control block
package rcgc_pkg;

   // Charge pump action, one-hot
   typedef enum logic [4:0] {
      PUMP_OFF = 5'h01,
      PUMP_CHG_N = 5'h02,
      PUMP_DIS_N = 5'h04,
      PUMP_DIS_F = 5'h08,
      PUMP_CHG_F = 5'h10
   } rcgc_pump_e;

endpackage

// *** core/rcgc_top.sv ***
// Read channel gain control: mode, gain word, pump steering, power and bypass
//
// Contract
// [R1] Gain mode bit low selects automatic loop, high selects programmable gain.
// [R2] Programmable mode disables detector, pump, exponentiator; gain from word only.
// [R3] Gain word from data register when servo gate low, servo register otherwise.
// [R4] Auto mode: charge below target, normal discharge between target and upper.
// [R5] Above upper threshold apply fast discharge until back below it.
// [R6] Fast recovery rising edge starts fast charge until target reached.
// [R7] Data capacitor when servo gate low, servo capacitor when high.
// [R8] Gain hold low disables all charge and discharge currents.
// [R9] Low impedance request zeroes gain, stops pump, low-impedance coupling.
// [R10] Coupling stays low impedance 200ns after request release.
// [R11] Standby low powers down amplifier, filter, pulse detector, demodulator.
// [R12] Sleep bit low powers down the variable gain amplifier.
// [R13] Test mode 5 bypasses filter, amplifier drives filter outputs.
// [R14] Fast recovery request synchronised; one trigger per rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "rcgc_consts.svh"

module rcgc_top #(
   parameter int LOW_IMPEDANCE_REQUEST_EXT_CYC = `RCGC_LOW_IMPEDANCE_REQUEST_EXT_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic nrst_i,
   // Serial control port
   input wire logic ser_en_i,
   input wire logic ser_clk_i,
   input wire logic ser_data_i,
   // Amplitude comparator results
   input wire logic amp_below_target_i,
   input wire logic amp_above_upper_i,
   // Controller and preamplifier controls
   input wire logic servo_field_gate_i,
   input wire logic gain_hold_n_i,
   input wire logic low_impedance_request_i,
   input wire logic fast_recovery_request_i,
   input wire logic standby_n_i,
   input wire logic [2:0] test_mode_i,
   // Gain converter and amplifier
   output logic [4:0] gain_word_o,
   output logic gain_zero_o,
   output logic agc_enable_o,
   output logic programmable_gain_select_o,
   output logic vga_low_impedance_request_input_o,
   // Charge pump
   output logic charge_normal_o,
   output logic discharge_normal_o,
   output logic discharge_fast_o,
   output logic charge_fast_o,
   output logic data_gain_capacitor_o,
   output logic servo_gain_capacitor_o,
   // Coupling, power and bypass
   output logic coupling_low_impedance_request_o,
   output logic vga_power_o,
   output logic filter_power_o,
   output logic pulse_det_power_o,
   output logic servo_demod_power_o,
   output logic filter_bypass_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] fsr_sync;
      logic fsr_prev;
      logic fast_chg;
      logic sclk_prev;
      logic [11:0] shift;
      logic [3:0] bitcnt;
      logic [7:0] sleep_reg;
      logic [7:0] mode_reg;
      logic [7:0] dgain_reg;
      logic [7:0] sgain_reg;
      rcgc_pkg::rcgc_pump_e pump;
      logic [4:0] gain_word;
      logic gain_zero;
      logic agc_en;
      logic programmable_gain_select;
      logic dcap;
      logic scap;
      logic coupling_low_impedance_request;
      logic vga_pwr;
      logic blk_pwr;
      logic bypass;
   } rcgc_state_s;

   rcgc_state_s st_ff;
   rcgc_state_s nxt_st;

   rcgc_low_impedance_request_if lz ();

   // Extension timer for the coupling network
   rcgc_low_impedance_request_timer #(.EXT_CYC(LOW_IMPEDANCE_REQUEST_EXT_CYC)) u_low_impedance_request (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .lz(lz)
   );

   assign lz.req = low_impedance_request_i;

   logic fsr_rise;
   logic sclk_rise;
   logic pgc_mode;
   logic pump_blocked;
   logic [11:0] frame;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      fsr_rise = st_ff.fsr_sync[1] && !st_ff.fsr_prev; // R14
      sclk_rise = ser_clk_i && !st_ff.sclk_prev;
      pgc_mode = st_ff.mode_reg[`RCGC_PGC_BIT]; // R1
      pump_blocked = 1'b0;
      frame = {st_ff.shift[10:0], ser_data_i};

      // Fast recovery synchroniser and edge memory
      nxt_st.fsr_sync = {st_ff.fsr_sync[0], fast_recovery_request_i}; // R14
      nxt_st.fsr_prev = st_ff.fsr_sync[1]; // R14
      nxt_st.sclk_prev = ser_clk_i;

      // Serial shift: address then data, MSB first
      if (!ser_en_i) begin
         nxt_st.bitcnt = '0;
      end else if (sclk_rise) begin
         nxt_st.shift = frame;
         if (st_ff.bitcnt == `RCGC_FRAME_BITS - 4'h1) begin
            nxt_st.bitcnt = '0;
            unique case (frame[`RCGC_ADDR_HI:`RCGC_ADDR_LO])
               `RCGC_ADDR_SLEEP: nxt_st.sleep_reg = frame[7:0];
               `RCGC_ADDR_MODE: nxt_st.mode_reg = frame[7:0];
               `RCGC_ADDR_DGAIN: nxt_st.dgain_reg = frame[7:0];
               `RCGC_ADDR_SGAIN: nxt_st.sgain_reg = frame[7:0];
               default: nxt_st.bitcnt = '0;
            endcase
         end else begin
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
         end
      end

      // Fast charge: armed by edge, ends at target, outside auto loop or on low impedance request
      if (pgc_mode || low_impedance_request_i) begin
         nxt_st.fast_chg = 1'b0;
      end else if (fsr_rise) begin
         nxt_st.fast_chg = 1'b1; // R6
      end else if (!amp_below_target_i) begin
         nxt_st.fast_chg = 1'b0; // R6
      end

      // Pump steering
      pump_blocked = pgc_mode || !gain_hold_n_i || low_impedance_request_i; // R2 R8 R9
      if (pump_blocked) begin
         nxt_st.pump = rcgc_pkg::PUMP_OFF; // R2 R8 R9
      end else if (nxt_st.fast_chg) begin
         nxt_st.pump = rcgc_pkg::PUMP_CHG_F; // R6
      end else if (amp_above_upper_i) begin
         nxt_st.pump = rcgc_pkg::PUMP_DIS_F; // R5
      end else if (amp_below_target_i) begin
         nxt_st.pump = rcgc_pkg::PUMP_CHG_N; // R4
      end else begin
         nxt_st.pump = rcgc_pkg::PUMP_DIS_N; // R4
      end

      // Gain path and capacitor choice
      nxt_st.programmable_gain_select = pgc_mode; // R1
      nxt_st.agc_en = !pgc_mode; // R2
      nxt_st.gain_word = servo_field_gate_i ? st_ff.sgain_reg[`RCGC_GAIN_MSB:0]
                                            : st_ff.dgain_reg[`RCGC_GAIN_MSB:0]; // R3
      nxt_st.dcap = !servo_field_gate_i; // R7
      nxt_st.scap = servo_field_gate_i; // R7
      nxt_st.gain_zero = low_impedance_request_i; // R9
      nxt_st.coupling_low_impedance_request = low_impedance_request_i || lz.extend; // R9 R10

      // Power and bypass
      nxt_st.vga_pwr = standby_n_i && st_ff.sleep_reg[`RCGC_SLEEP_BIT]; // R11 R12
      nxt_st.blk_pwr = standby_n_i; // R11
      nxt_st.bypass = (test_mode_i == `RCGC_TEST_BYPASS); // R13
   end

   // State register
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         st_ff <= '0;
         st_ff.sleep_reg <= `RCGC_REG_RESET;
         st_ff.mode_reg <= `RCGC_REG_RESET;
         st_ff.dgain_reg <= `RCGC_REG_RESET;
         st_ff.sgain_reg <= `RCGC_REG_RESET;
         st_ff.pump <= rcgc_pkg::PUMP_OFF;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign gain_word_o = st_ff.gain_word;
   assign gain_zero_o = st_ff.gain_zero;
   assign agc_enable_o = st_ff.agc_en;
   assign programmable_gain_select_o = st_ff.programmable_gain_select;
   assign vga_low_impedance_request_input_o = st_ff.gain_zero;
   // One-hot pump bits go out directly, no decode after the flop
   assign charge_normal_o = st_ff.pump[`RCGC_PUMP_CHG_N_BIT];
   assign discharge_normal_o = st_ff.pump[`RCGC_PUMP_DIS_N_BIT];
   assign discharge_fast_o = st_ff.pump[`RCGC_PUMP_DIS_F_BIT];
   assign charge_fast_o = st_ff.pump[`RCGC_PUMP_CHG_F_BIT];
   assign data_gain_capacitor_o = st_ff.dcap;
   assign servo_gain_capacitor_o = st_ff.scap;
   assign coupling_low_impedance_request_o = st_ff.coupling_low_impedance_request;
   assign vga_power_o = st_ff.vga_pwr;
   assign filter_power_o = st_ff.blk_pwr;
   assign pulse_det_power_o = st_ff.blk_pwr;
   assign servo_demod_power_o = st_ff.blk_pwr;
   assign filter_bypass_o = st_ff.bypass;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   a_pgc_mode_follow: assert property ($past(nrst_i) |-> agc_enable_o == !$past(st_ff.mode_reg[`RCGC_PGC_BIT])) // R1
      else $error("Loop enable does not follow mode bit");

   a_pgc_pump_off: assert property (st_ff.mode_reg[`RCGC_PGC_BIT] |=> st_ff.pump == rcgc_pkg::PUMP_OFF) // R2
      else $error("Pump active in programmable mode");

   a_gain_word_src: assert property (servo_field_gate_i
      |=> gain_word_o == $past(st_ff.sgain_reg[`RCGC_GAIN_MSB:0])) // R3
      else $error("Servo gain word not selected");

   a_pump_normal: assert property (!st_ff.mode_reg[`RCGC_PGC_BIT] && gain_hold_n_i && !low_impedance_request_i
      && !nxt_st.fast_chg && !amp_above_upper_i && amp_below_target_i |=> charge_normal_o) // R4
      else $error("Normal charge missing");

   a_fast_discharge: assert property (!st_ff.mode_reg[`RCGC_PGC_BIT] && gain_hold_n_i && !low_impedance_request_i
      && !nxt_st.fast_chg && amp_above_upper_i |=> discharge_fast_o) // R5
      else $error("Fast discharge missing");

   a_fast_recovery: assert property ($rose(st_ff.fsr_sync[1]) && !st_ff.mode_reg[`RCGC_PGC_BIT]
      && gain_hold_n_i && !low_impedance_request_i |=> charge_fast_o) // R6
      else $error("Fast charge not started");

   a_cap_select: assert property ($past(nrst_i) |-> data_gain_capacitor_o == !$past(servo_field_gate_i)) // R7
      else $error("Capacitor select wrong");

   a_hold_freeze: assert property (!gain_hold_n_i |=> st_ff.pump == rcgc_pkg::PUMP_OFF) // R8
      else $error("Pump active during hold");

   a_low_impedance_request_zero: assert property (low_impedance_request_i |=> gain_zero_o && coupling_low_impedance_request_o
      && !charge_normal_o && !discharge_normal_o) // R9
      else $error("Low impedance not applied");

   a_standby_down: assert property (!standby_n_i |=> !vga_power_o && !filter_power_o && !servo_demod_power_o) // R11
      else $error("Standby not powering down");

   a_sleep_down: assert property (!st_ff.sleep_reg[`RCGC_SLEEP_BIT] |=> !vga_power_o) // R12
      else $error("Sleep not powering down amplifier");

   a_test_bypass: assert property (test_mode_i == `RCGC_TEST_BYPASS |=> filter_bypass_o) // R13
      else $error("Filter bypass missing");

   a_fsr_one_shot: assert property (st_ff.fsr_prev && !st_ff.fast_chg |=> !st_ff.fast_chg) // R14
      else $error("Held fast recovery retriggered");

   c_fast_recovery: cover property ($rose(charge_fast_o) ##[1:50] charge_normal_o);
   c_fast_discharge: cover property (discharge_fast_o ##1 discharge_normal_o);
   c_low_impedance_request_release: cover property ($fell(low_impedance_request_i) ##[8:10] !coupling_low_impedance_request_o);

endmodule // rcgc_top

`default_nettype wire

// *** verification/rcgc_ctl_model.sv ***
// Disk controller model driving the serial control port
`timescale 1ns/1ps
`default_nettype none

module rcgc_ctl_model (
   // Clock
   input wire logic clock_i,
   // Serial control port
   output var logic ser_en_o,
   output var logic ser_clk_o,
   output var logic ser_data_o
);
   // Idle: no frame, bit clock parked low
   initial begin
      ser_en_o = 1'b0;
      ser_clk_o = 1'b0;
      ser_data_o = 1'b0;
   end

   // One write frame, address then data, MSB first
   task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
      logic [11:0] frame;
      frame = {addr, data};
      @(posedge clock_i);
      ser_en_o <= 1'b1;
      for (int i = 11; i >= 0; i--) begin
         ser_clk_o <= 1'b0;
         ser_data_o <= frame[i];
         @(posedge clock_i);
         ser_clk_o <= 1'b1;
         @(posedge clock_i);
      end
      // Released data line shows the inverse of the last bit
      ser_clk_o <= 1'b0;
      ser_en_o <= 1'b0;
      ser_data_o <= ~frame[0];
   endtask
endmodule // rcgc_ctl_model

`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the read channel gain control block
`timescale 1ns/1ps
`default_nettype none
`include "rcgc_consts.svh"

module testbench;
   localparam int EXT = `RCGC_LOW_IMPEDANCE_REQUEST_EXT_CYC;
   logic clock_i, nrst_i, ser_en_i, ser_clk_i, ser_data_i;
   logic amp_below_target_i, amp_above_upper_i, servo_field_gate_i, gain_hold_n_i;
   logic low_impedance_request_i, fast_recovery_request_i, standby_n_i;
   logic [2:0] test_mode_i;
   logic [4:0] gain_word_o;
   logic gain_zero_o, agc_enable_o, programmable_gain_select_o, vga_low_impedance_request_input_o;
   logic charge_normal_o, discharge_normal_o, discharge_fast_o, charge_fast_o;
   logic data_gain_capacitor_o, servo_gain_capacitor_o, coupling_low_impedance_request_o;
   logic vga_power_o, filter_power_o, pulse_det_power_o, servo_demod_power_o, filter_bypass_o;
   logic [3:0] pump;
   int failures = 0;
   int n_checks = 0;
   int n;

   // Pump outputs gathered, fast charge on top
   assign pump = {charge_fast_o, discharge_fast_o, discharge_normal_o, charge_normal_o};

   rcgc_top #(.LOW_IMPEDANCE_REQUEST_EXT_CYC(EXT)) uut (.clock_i, .nrst_i, .ser_en_i, .ser_clk_i, .ser_data_i,
      .amp_below_target_i, .amp_above_upper_i, .servo_field_gate_i, .gain_hold_n_i,
      .low_impedance_request_i, .fast_recovery_request_i, .standby_n_i, .test_mode_i,
      .gain_word_o, .gain_zero_o, .agc_enable_o, .programmable_gain_select_o, .vga_low_impedance_request_input_o,
      .charge_normal_o, .discharge_normal_o, .discharge_fast_o, .charge_fast_o,
      .data_gain_capacitor_o, .servo_gain_capacitor_o, .coupling_low_impedance_request_o, .vga_power_o,
      .filter_power_o, .pulse_det_power_o, .servo_demod_power_o, .filter_bypass_o);

   rcgc_ctl_model u_ctl (.clock_i(clock_i), .ser_en_o(ser_en_i), .ser_clk_o(ser_clk_i),
      .ser_data_o(ser_data_i));

   // Clock, 25 ns period
   always #12.5 clock_i = ~clock_i;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic waitc(input int c);
      repeat (c) @(posedge clock_i);
      #1;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_power;
      waitc(3);
      chk(vga_power_o, 1'b0);
      chk({filter_power_o, pulse_det_power_o, servo_demod_power_o}, 3'h7);
      u_ctl.write_reg(`RCGC_ADDR_SLEEP, 8'h80);
      waitc(2);
      chk(vga_power_o, 1'b1);
      @(posedge clock_i);
      standby_n_i <= 1'b0;
      waitc(2);
      chk({vga_power_o, filter_power_o, pulse_det_power_o, servo_demod_power_o}, 4'h0);
      @(posedge clock_i);
      standby_n_i <= 1'b1;
      waitc(2);
      chk({vga_power_o, filter_power_o, pulse_det_power_o, servo_demod_power_o}, 4'hF);
   endtask

   task automatic t_pgc;
      u_ctl.write_reg(`RCGC_ADDR_DGAIN, 8'h35);
      u_ctl.write_reg(`RCGC_ADDR_SGAIN, 8'h0A);
      u_ctl.write_reg(4'hA, 8'h1F);
      u_ctl.write_reg(`RCGC_ADDR_MODE, 8'h80);
      @(posedge clock_i);
      amp_below_target_i <= 1'b1;
      waitc(2);
      chk({programmable_gain_select_o, agc_enable_o}, 2'h2);
      chk(pump, 4'h0);
      chk(gain_word_o, 5'h15);
      chk({servo_gain_capacitor_o, data_gain_capacitor_o}, 2'h1);
      @(posedge clock_i);
      servo_field_gate_i <= 1'b1;
      waitc(2);
      chk(gain_word_o, 5'h0A);
      chk({servo_gain_capacitor_o, data_gain_capacitor_o}, 2'h2);
      @(posedge clock_i);
      servo_field_gate_i <= 1'b0;
      amp_below_target_i <= 1'b0;
      u_ctl.write_reg(`RCGC_ADDR_MODE, 8'h00);
      waitc(2);
      chk({programmable_gain_select_o, agc_enable_o}, 2'h1);
   endtask

   task automatic t_pump;
      logic [1:0] amp [3] = '{2'h2, 2'h0, 2'h1};
      logic [3:0] exp [3] = '{4'h1, 4'h2, 4'h4};
      for (int i = 0; i < 3; i++) begin
         @(posedge clock_i);
         {amp_below_target_i, amp_above_upper_i} <= amp[i];
         waitc(2);
         chk(pump, exp[i]);
      end
      @(posedge clock_i);
      gain_hold_n_i <= 1'b0;
      waitc(2);
      chk(pump, 4'h0);
      @(posedge clock_i);
      gain_hold_n_i <= 1'b1;
      waitc(2);
      chk(pump, 4'h4);
      @(posedge clock_i);
      amp_above_upper_i <= 1'b0;
      waitc(2);
      chk(pump, 4'h2);
   endtask

   task automatic t_fast;
      @(posedge clock_i);
      amp_below_target_i <= 1'b1;
      fast_recovery_request_i <= 1'b1;
      waitc(4);
      chk(pump, 4'h8);
      @(posedge clock_i);
      amp_below_target_i <= 1'b0;
      waitc(3);
      chk(pump, 4'h2);
      @(posedge clock_i);
      amp_below_target_i <= 1'b1;
      waitc(4);
      chk(pump, 4'h1);
      @(posedge clock_i);
      fast_recovery_request_i <= 1'b0;
      waitc(2);
      @(posedge clock_i);
      fast_recovery_request_i <= 1'b1;
      waitc(4);
      chk(pump, 4'h8);
   endtask

   task automatic t_low_impedance_request;
      @(posedge clock_i);
      low_impedance_request_i <= 1'b1;
      waitc(2);
      chk({gain_zero_o, vga_low_impedance_request_input_o, coupling_low_impedance_request_o}, 3'h7);
      chk(pump, 4'h0);
      @(posedge clock_i);
      low_impedance_request_i <= 1'b0;
      waitc(1);
      for (n = 0; n < 10 && gain_zero_o !== 1'b0; n++) waitc(1);
      for (n = 0; n < 50 && coupling_low_impedance_request_o === 1'b1; n++) waitc(1);
      chk(n, EXT);
      chk(pump, 4'h1);
      @(posedge clock_i);
      amp_below_target_i <= 1'b0;
   endtask

   task automatic t_bypass;
      for (int m = 0; m < 8; m++) begin
         @(posedge clock_i);
         test_mode_i <= m[2:0];
         waitc(2);
         chk(filter_bypass_o, m == `RCGC_TEST_BYPASS);
      end
   endtask

   // Main sequence
   initial begin
      clock_i = 1'b0;
      nrst_i = 1'b0;
      {amp_below_target_i, amp_above_upper_i, servo_field_gate_i} = 3'h0;
      {low_impedance_request_i, fast_recovery_request_i, test_mode_i} = 5'h00;
      gain_hold_n_i = 1'b1;
      standby_n_i = 1'b1;
      repeat (10) @(posedge clock_i);
      nrst_i <= 1'b1;
      t_power();
      t_pgc();
      t_pump();
      t_fast();
      t_low_impedance_request();
      t_bypass();
      end_of_test();
   end

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clock_i);
      failures++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      end_of_test();
   end
endmodule // testbench

`default_nettype wire
